/* File: rtl/cfg_bank_regs.svh */
`ifndef CFG_BANK_REGS_SVH
`define CFG_BANK_REGS_SVH

`define ADDR_BITS 8
`define WORD_BITS 6
`define NUM_REGS 24
`define LINE_BITS 12

`define OFF_AFE_OPERATION_LO 8'h00
`define OFF_AFE_OPERATION_HI 8'h01
`define OFF_VGA_GAIN_LO 8'h02
`define OFF_VGA_GAIN_HI 8'h03
`define OFF_BLACK_CLAMP_LEVEL_LO 8'h04
`define OFF_BLACK_CLAMP_LEVEL_HI 8'h05
`define OFF_AFE_CONTROL 8'h06
`define OFF_COLOR0_PIXEL_GAIN 8'h07
`define OFF_COLOR1_PIXEL_GAIN 8'h08
`define OFF_COLOR2_PIXEL_GAIN 8'h09
`define OFF_COLOR3_PIXEL_GAIN 8'h0A
`define OFF_INIT_SETTING_B 8'h0F
`define OFF_OUTPUT_ENABLE 8'h16
`define OFF_UPDATE_LINE_LO 8'h17
`define OFF_UPDATE_LINE_HI 8'h18
`define OFF_UPDATE_LOCK 8'h19
`define OFF_DATA_OUT_PHASE 8'h1B
`define OFF_INPUT_RESTORE_DISABLE 8'h1C
`define OFF_SYNC_POLARITY 8'h1D
`define OFF_NEXT_FIELD_VALUE 8'h1E
`define OFF_BLANK_RESYNC 8'h1F
`define OFF_INIT_SETTING_A 8'h20
`define OFF_TIMING_CORE_RESET_RELEASE 8'h26
`define OFF_DUMMY_CLAMP_SOURCE 8'h64

`define RST_ZERO 6'h00
`define RST_VGA_GAIN_LO 6'h16
`define RST_VGA_GAIN_HI 6'h02
`define RST_BLACK_CLAMP_LEVEL_HI 6'h02
`define RST_NEXT_FIELD_VALUE 6'h01
`define RST_DUMMY_CLAMP_SOURCE 6'h01

`define MASK_1BIT 6'h01
`define MASK_2BIT 6'h03
`define MASK_4BIT 6'h0F
`define MASK_6BIT 6'h3F

`endif

/* File: rtl/cfg_bank_pkg.sv */
package cfg_bank_pkg;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_ADDR = 3'b010,
        RX_DATA = 3'b100
    } rx_state_type;

    typedef logic [4:0] reg_index_type;

    typedef struct packed {
        logic [5:0] reset_value;
        logic [5:0] mask;
        logic lo_half;
        logic load_class;
    } reg_attr_type;

endpackage

/* File: rtl/cfg_write_if.sv */
`timescale 1ns/10ps
`include "cfg_bank_regs.svh"

interface cfg_write_if;
    logic wr_valid;
    logic [`ADDR_BITS-1:0] wr_addr;
    logic [`WORD_BITS-1:0] wr_data;
    logic load_done;

    modport rx (output wr_valid, output wr_addr, output wr_data, output load_done);
    modport bank (input wr_valid, input wr_addr, input wr_data, input load_done);
endinterface

/* File: rtl/serial_word_receiver.sv */
`timescale 1ns/10ps
`include "cfg_bank_regs.svh"

module serial_word_receiver
    import cfg_bank_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic serial_load_strobe_n,
    input wire logic serial_clock,
    input wire logic serial_data,
    cfg_write_if.rx wr
);

    rx_state_type state_reg;
    logic sck_prev_reg;
    logic load_prev_reg;
    logic [3:0] bit_cnt_reg;
    logic [`ADDR_BITS-1:0] shift_reg;
    logic sck_rise;
    logic [`ADDR_BITS-1:0] shift_next;

    assign sck_rise = serial_clock & ~sck_prev_reg;
    // lsb first: new bit enters at the top
    assign shift_next = {serial_data, shift_reg[`ADDR_BITS-1:1]};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sck_prev_reg <= 1'b0;
            load_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= serial_clock;
            load_prev_reg <= serial_load_strobe_n;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr.load_done <= 1'b0;
        end else begin
            wr.load_done <= serial_load_strobe_n & ~load_prev_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= RX_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            wr.wr_valid <= 1'b0;
            wr.wr_addr <= 8'h00;
            wr.wr_data <= 6'h00;
        end else begin
            wr.wr_valid <= 1'b0;
            if (wr.wr_valid) begin
                wr.wr_addr <= wr.wr_addr + 8'h01;
            end
            if (serial_load_strobe_n) begin
                state_reg <= RX_IDLE;
                bit_cnt_reg <= 4'h0;
            end else begin
                case (state_reg)
                    RX_IDLE: begin
                        state_reg <= RX_ADDR;
                        bit_cnt_reg <= 4'h0;
                    end
                    RX_ADDR: begin
                        if (sck_rise) begin
                            shift_reg <= shift_next;
                            if (bit_cnt_reg == 4'(`ADDR_BITS - 1)) begin
                                wr.wr_addr <= shift_next;
                                bit_cnt_reg <= 4'h0;
                                state_reg <= RX_DATA;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    RX_DATA: begin
                        if (sck_rise) begin
                            shift_reg <= shift_next;
                            if (bit_cnt_reg == 4'(`WORD_BITS - 1)) begin
                                wr.wr_data <= shift_next[`ADDR_BITS-1:`ADDR_BITS-`WORD_BITS];
                                wr.wr_valid <= 1'b1;
                                bit_cnt_reg <= 4'h0;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    default: begin
                        state_reg <= RX_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // serial_word_receiver

/* File: rtl/sync_update_point.sv */
`timescale 1ns/10ps
`include "cfg_bank_regs.svh"

module sync_update_point (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic vertical_sync,
    input wire logic horizontal_sync,
    input wire logic sync_polarity,
    input wire logic [`LINE_BITS-1:0] update_line,
    output logic vd_edge,
    output logic sync_update
);

    logic vd_act_prev_reg;
    logic hd_act_prev_reg;
    logic [`LINE_BITS-1:0] line_cnt_reg;
    logic armed_reg;
    logic vd_act;
    logic hd_act;
    logic hd_edge;

    // polarity 0: low active, so active edge is the falling pin edge
    assign vd_act = vertical_sync ^ ~sync_polarity;
    assign hd_act = horizontal_sync ^ ~sync_polarity;
    assign vd_edge = vd_act & ~vd_act_prev_reg;
    assign hd_edge = hd_act & ~hd_act_prev_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vd_act_prev_reg <= 1'b0;
            hd_act_prev_reg <= 1'b0;
        end else begin
            vd_act_prev_reg <= vd_act;
            hd_act_prev_reg <= hd_act;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            line_cnt_reg <= 12'h000;
            armed_reg <= 1'b0;
            sync_update <= 1'b0;
        end else begin
            sync_update <= 1'b0;
            if (vd_edge) begin
                line_cnt_reg <= 12'h000;
                armed_reg <= 1'b1;
            end else if (hd_edge) begin
                line_cnt_reg <= line_cnt_reg + 12'h001;
                if (armed_reg && line_cnt_reg == update_line) begin
                    sync_update <= 1'b1;
                    armed_reg <= 1'b0;
                end
            end
        end
    end

endmodule // sync_update_point

/* File: rtl/serial_config_register_bank.sv */
`timescale 1ns/10ps
`include "cfg_bank_regs.svh"

module serial_config_register_bank
    import cfg_bank_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic serial_load_strobe_n,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic vertical_sync,
    input wire logic horizontal_sync,
    input wire logic preblank_pulse,
    input wire logic blank_pulse_in,
    input wire logic h_clock_phase,
    input wire logic dummy_black_clamp,
    input wire logic internal_clamp_pulse,
    output logic [7:0] afe_operation,
    output logic [9:0] vga_gain,
    output logic [7:0] black_clamp_level,
    output logic [5:0] afe_control,
    output logic [5:0] color0_pixel_gain,
    output logic [5:0] color1_pixel_gain,
    output logic [5:0] color2_pixel_gain,
    output logic [5:0] color3_pixel_gain,
    output logic [5:0] init_setting_a,
    output logic [5:0] init_setting_b,
    output logic [5:0] data_out_phase,
    output logic outputs_active,
    output logic timing_core_reset,
    output logic field_is_even,
    output logic restore_enable,
    output logic blank_pulse_out,
    output logic clamp_pulse_out
);

    // ----------------------------------------------------------------
    // register attributes
    // ----------------------------------------------------------------
    function automatic reg_attr_type attr_of(input reg_index_type idx);
        reg_attr_type a;
        a = '{`RST_ZERO, `MASK_6BIT, 1'b0, 1'b0};
        case (idx)
            5'd0: a = '{`RST_ZERO, `MASK_6BIT, 1'b1, 1'b1};
            5'd1: a = '{`RST_ZERO, `MASK_2BIT, 1'b0, 1'b1};
            5'd2: a = '{`RST_VGA_GAIN_LO, `MASK_6BIT, 1'b1, 1'b0};
            5'd3: a = '{`RST_VGA_GAIN_HI, `MASK_4BIT, 1'b0, 1'b0};
            5'd4: a = '{`RST_ZERO, `MASK_6BIT, 1'b1, 1'b0};
            5'd5: a = '{`RST_BLACK_CLAMP_LEVEL_HI, `MASK_2BIT, 1'b0, 1'b0};
            5'd6: a = '{`RST_ZERO, `MASK_6BIT, 1'b0, 1'b1};
            5'd12: a = '{`RST_ZERO, `MASK_1BIT, 1'b0, 1'b0};
            5'd13: a = '{`RST_ZERO, `MASK_6BIT, 1'b1, 1'b0};
            5'd15: a = '{`RST_ZERO, `MASK_1BIT, 1'b0, 1'b1};
            5'd17: a = '{`RST_ZERO, `MASK_1BIT, 1'b0, 1'b0};
            5'd18: a = '{`RST_ZERO, `MASK_1BIT, 1'b0, 1'b1};
            5'd19: a = '{`RST_NEXT_FIELD_VALUE, `MASK_1BIT, 1'b0, 1'b1};
            5'd20: a = '{`RST_ZERO, `MASK_1BIT, 1'b0, 1'b1};
            5'd22: a = '{`RST_ZERO, `MASK_1BIT, 1'b0, 1'b1};
            5'd23: a = '{`RST_DUMMY_CLAMP_SOURCE, `MASK_1BIT, 1'b0, 1'b0};
            default: a = '{`RST_ZERO, `MASK_6BIT, 1'b0, 1'b0};
        endcase
        return a;
    endfunction

    function automatic logic [5:0] decode(input logic [`ADDR_BITS-1:0] addr);
        logic [5:0] r;
        r = 6'h00;
        case (addr)
            `OFF_AFE_OPERATION_LO: r = {1'b1, 5'd0};
            `OFF_AFE_OPERATION_HI: r = {1'b1, 5'd1};
            `OFF_VGA_GAIN_LO: r = {1'b1, 5'd2};
            `OFF_VGA_GAIN_HI: r = {1'b1, 5'd3};
            `OFF_BLACK_CLAMP_LEVEL_LO: r = {1'b1, 5'd4};
            `OFF_BLACK_CLAMP_LEVEL_HI: r = {1'b1, 5'd5};
            `OFF_AFE_CONTROL: r = {1'b1, 5'd6};
            `OFF_COLOR0_PIXEL_GAIN: r = {1'b1, 5'd7};
            `OFF_COLOR1_PIXEL_GAIN: r = {1'b1, 5'd8};
            `OFF_COLOR2_PIXEL_GAIN: r = {1'b1, 5'd9};
            `OFF_COLOR3_PIXEL_GAIN: r = {1'b1, 5'd10};
            `OFF_INIT_SETTING_B: r = {1'b1, 5'd11};
            `OFF_OUTPUT_ENABLE: r = {1'b1, 5'd12};
            `OFF_UPDATE_LINE_LO: r = {1'b1, 5'd13};
            `OFF_UPDATE_LINE_HI: r = {1'b1, 5'd14};
            `OFF_UPDATE_LOCK: r = {1'b1, 5'd15};
            `OFF_DATA_OUT_PHASE: r = {1'b1, 5'd16};
            `OFF_INPUT_RESTORE_DISABLE: r = {1'b1, 5'd17};
            `OFF_SYNC_POLARITY: r = {1'b1, 5'd18};
            `OFF_NEXT_FIELD_VALUE: r = {1'b1, 5'd19};
            `OFF_BLANK_RESYNC: r = {1'b1, 5'd20};
            `OFF_INIT_SETTING_A: r = {1'b1, 5'd21};
            `OFF_TIMING_CORE_RESET_RELEASE: r = {1'b1, 5'd22};
            `OFF_DUMMY_CLAMP_SOURCE: r = {1'b1, 5'd23};
            default: r = 6'h00;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // serial front end and sync update point
    // ----------------------------------------------------------------
    cfg_write_if wr ();

    logic vd_edge;
    logic sync_update;
    logic [5:0] shadow_reg [`NUM_REGS];
    logic [5:0] active_reg [`NUM_REGS];
    logic [`NUM_REGS-1:0] pending_reg;
    logic [`NUM_REGS-1:0] pending_set;
    logic [`NUM_REGS-1:0] pending_clear;
    logic [5:0] hit;
    reg_index_type hit_idx;
    logic [`LINE_BITS-1:0] update_line;
    logic lock_active;

    serial_word_receiver u_rx (
        .sys_clk(sys_clk),
        .srst(srst),
        .serial_load_strobe_n(serial_load_strobe_n),
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .wr(wr.rx)
    );

    assign update_line = {active_reg[14], active_reg[13]};
    assign lock_active = active_reg[15][0];

    sync_update_point u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .vertical_sync(vertical_sync),
        .horizontal_sync(horizontal_sync),
        .sync_polarity(active_reg[18][0]),
        .update_line(update_line),
        .vd_edge(vd_edge),
        .sync_update(sync_update)
    );

    // ----------------------------------------------------------------
    // write staging and transfer
    // ----------------------------------------------------------------
    assign hit = decode(wr.wr_addr);
    assign hit_idx = hit[4:0];

    always_comb begin
        pending_set = '0;
        if (wr.wr_valid && hit[5] && !attr_of(hit_idx).lo_half) begin
            pending_set[hit_idx] = 1'b1;
            if (hit_idx != 5'd0 && attr_of(hit_idx - 5'd1).lo_half) begin
                pending_set[hit_idx - 5'd1] = 1'b1;
            end
        end
    end

    always_comb begin
        pending_clear = '0;
        for (int i = 0; i < `NUM_REGS; i++) begin
            if (attr_of(5'(i)).load_class) begin
                pending_clear[i] = wr.load_done;
            end else begin
                pending_clear[i] = sync_update & ~lock_active;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < `NUM_REGS; i++) begin
                shadow_reg[i] <= attr_of(5'(i)).reset_value;
            end
        end else if (wr.wr_valid && hit[5]) begin
            shadow_reg[hit_idx] <= wr.wr_data & attr_of(hit_idx).mask;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pending_reg <= '0;
        end else begin
            // a new write in the transfer cycle stays pending
            pending_reg <= (pending_reg & ~pending_clear) | pending_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < `NUM_REGS; i++) begin
                active_reg[i] <= attr_of(5'(i)).reset_value;
            end
        end else begin
            for (int i = 0; i < `NUM_REGS; i++) begin
                if (pending_reg[i] && pending_clear[i]) begin
                    active_reg[i] <= shadow_reg[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            afe_operation <= 8'h00;
            vga_gain <= {4'(`RST_VGA_GAIN_HI), `RST_VGA_GAIN_LO};
            black_clamp_level <= {2'(`RST_BLACK_CLAMP_LEVEL_HI), `RST_ZERO};
            afe_control <= 6'h00;
            color0_pixel_gain <= 6'h00;
            color1_pixel_gain <= 6'h00;
            color2_pixel_gain <= 6'h00;
            color3_pixel_gain <= 6'h00;
            init_setting_a <= 6'h00;
            init_setting_b <= 6'h00;
            data_out_phase <= 6'h00;
        end else begin
            afe_operation <= {active_reg[1][1:0], active_reg[0]};
            vga_gain <= {active_reg[3][3:0], active_reg[2]};
            black_clamp_level <= {active_reg[5][1:0], active_reg[4]};
            afe_control <= active_reg[6];
            color0_pixel_gain <= active_reg[7];
            color1_pixel_gain <= active_reg[8];
            color2_pixel_gain <= active_reg[9];
            color3_pixel_gain <= active_reg[10];
            init_setting_a <= active_reg[21];
            init_setting_b <= active_reg[11];
            data_out_phase <= active_reg[16];
        end
    end

    // ----------------------------------------------------------------
    // timing controls
    // ----------------------------------------------------------------
    logic enable;

    assign enable = active_reg[12][0];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            outputs_active <= 1'b0;
            timing_core_reset <= 1'b1;
            restore_enable <= 1'b1;
        end else begin
            outputs_active <= enable;
            timing_core_reset <= ~active_reg[22][0];
            restore_enable <= ~(active_reg[17][0] & preblank_pulse);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            field_is_even <= 1'b0;
        end else if (!enable) begin
            field_is_even <= 1'b0;
        end else if (vd_edge) begin
            field_is_even <= active_reg[19][0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            blank_pulse_out <= 1'b0;
        end else if (!enable) begin
            blank_pulse_out <= 1'b0;
        end else if (!active_reg[20][0] || h_clock_phase) begin
            blank_pulse_out <= blank_pulse_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clamp_pulse_out <= 1'b0;
        end else if (!enable) begin
            clamp_pulse_out <= 1'b0;
        end else begin
            clamp_pulse_out <= active_reg[23][0] ? dummy_black_clamp : internal_clamp_pulse;
        end
    end

endmodule // serial_config_register_bank

/* File: sim/cfg_bank_assertions.sv */
`timescale 1ns/10ps
module cfg_bank_assertions (
    input logic sys_clk,
    input logic srst,
    input logic serial_load_strobe_n,
    input logic preblank_pulse,
    input logic blank_pulse_in,
    input logic dummy_black_clamp,
    input logic internal_clamp_pulse,
    input logic [7:0] afe_operation,
    input logic [9:0] vga_gain,
    input logic [7:0] black_clamp_level,
    input logic outputs_active,
    input logic timing_core_reset,
    input logic field_is_even,
    input logic restore_enable,
    input logic blank_pulse_out,
    input logic clamp_pulse_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence frame_open;
        $fell(serial_load_strobe_n) ##1 !serial_load_strobe_n;
    endsequence
    sequence both_active;
        $past(outputs_active) && outputs_active;
    endsequence
    reset_defaults_a: assert property ($fell(srst) |-> vga_gain == 10'h096 &&
        black_clamp_level == 8'h80 && timing_core_reset && restore_enable && !outputs_active)
        else $error("reset defaults wrong");
    frame_hold_a: assert property (frame_open |-> $stable(afe_operation) && $stable(timing_core_reset))
        else $error("load value moved inside frame");
    restore_low_a: assert property (!restore_enable |-> $past(preblank_pulse))
        else $error("restore off outside preblank");
    outputs_gate_a: assert property (!outputs_active && !$past(outputs_active) |->
        !clamp_pulse_out && !blank_pulse_out && !field_is_even)
        else $error("output active while disabled");
    clamp_select_a: assert property (both_active |-> clamp_pulse_out == $past(dummy_black_clamp) ||
        clamp_pulse_out == $past(internal_clamp_pulse))
        else $error("clamp from no source");
    blank_path_a: assert property (both_active |-> blank_pulse_out == $past(blank_pulse_in) ||
        $stable(blank_pulse_out))
        else $error("blank output neither follows nor holds");
    core_release_a: assert property ($fell(timing_core_reset) |-> $past(serial_load_strobe_n))
        else $error("core released inside frame");
    sync_class_a: assert property ($changed(vga_gain) |-> $past(serial_load_strobe_n))
        else $error("gain moved inside frame");
endmodule // cfg_bank_assertions

bind serial_config_register_bank cfg_bank_assertions cfg_bank_assertions_i (.sys_clk(sys_clk), .srst(srst),
    .serial_load_strobe_n(serial_load_strobe_n), .preblank_pulse(preblank_pulse), .blank_pulse_in(blank_pulse_in),
    .dummy_black_clamp(dummy_black_clamp), .internal_clamp_pulse(internal_clamp_pulse),
    .afe_operation(afe_operation), .vga_gain(vga_gain), .black_clamp_level(black_clamp_level),
    .outputs_active(outputs_active), .timing_core_reset(timing_core_reset), .field_is_even(field_is_even),
    .restore_enable(restore_enable), .blank_pulse_out(blank_pulse_out), .clamp_pulse_out(clamp_pulse_out));

/* File: sim/host_model.sv */
`timescale 1ns/10ps
module host_model (
    input logic sys_clk,
    output logic serial_load_strobe_n,
    output logic serial_clock,
    output logic serial_data
);
    logic busy = 0;
    initial begin
        serial_load_strobe_n = 1;
        serial_clock = 0;
        serial_data = 0;
    end
    // idle data line toggles so no stale bit looks valid
    always @(posedge sys_clk) begin
        if (!busy) begin
            serial_data <= ~serial_data;
        end
    end
    task automatic send_bit(input logic b);
        serial_data <= b;
        serial_clock <= 0;
        repeat (2) @(posedge sys_clk);
        serial_clock <= 1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic frame(input logic [7:0] addr, input logic [5:0] words [$]);
        @(posedge sys_clk);
        busy = 1;
        serial_load_strobe_n <= 0;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            send_bit(addr[i]);
        end
        foreach (words[w]) begin
            for (int i = 0; i < 6; i++) begin
                send_bit(words[w][i]);
            end
        end
        serial_clock <= 0;
        repeat (2) @(posedge sys_clk);
        serial_load_strobe_n <= 1;
        busy = 0;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule // host_model

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
    logic sys_clk = 0;
    logic srst = 1;
    logic vertical_sync = 1, horizontal_sync = 1, preblank_pulse = 1, dummy_black_clamp = 1;
    logic blank_pulse_in = 0, h_clock_phase = 0, internal_clamp_pulse = 0;
    logic serial_load_strobe_n, serial_clock, serial_data;
    logic [7:0] afe_operation, black_clamp_level;
    logic [9:0] vga_gain;
    logic [5:0] init_setting_a, init_setting_b, afe_control, data_out_phase, d;
    logic outputs_active, timing_core_reset, field_is_even, restore_enable, clamp_pulse_out, icp_prev;
    logic [15:0] rnd = 16'hA951;
    int n_mismatch = 0, num_checks = 0;
    typedef struct {int idx; logic [15:0] exp;} note_type;
    note_type notes [$];

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    host_model host_model_i (.sys_clk(sys_clk), .serial_load_strobe_n(serial_load_strobe_n),
        .serial_clock(serial_clock), .serial_data(serial_data));
    serial_config_register_bank serial_config_register_bank_i (.sys_clk(sys_clk), .srst(srst),
        .serial_load_strobe_n(serial_load_strobe_n), .serial_clock(serial_clock), .serial_data(serial_data),
        .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync), .preblank_pulse(preblank_pulse),
        .blank_pulse_in(blank_pulse_in), .h_clock_phase(h_clock_phase), .dummy_black_clamp(dummy_black_clamp),
        .internal_clamp_pulse(internal_clamp_pulse), .afe_operation(afe_operation), .vga_gain(vga_gain),
        .black_clamp_level(black_clamp_level), .afe_control(afe_control), .color0_pixel_gain(), .color1_pixel_gain(),
        .color2_pixel_gain(), .color3_pixel_gain(), .init_setting_a(init_setting_a), .init_setting_b(init_setting_b),
        .data_out_phase(data_out_phase), .outputs_active(outputs_active), .timing_core_reset(timing_core_reset),
        .field_is_even(field_is_even), .restore_enable(restore_enable), .blank_pulse_out(),
        .clamp_pulse_out(clamp_pulse_out));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge sys_clk) begin
        rnd <= lfsr_next(rnd);
        blank_pulse_in <= rnd[0];
        h_clock_phase <= rnd[1];
        internal_clamp_pulse <= rnd[2];
        icp_prev <= internal_clamp_pulse;
    end
    function automatic logic [15:0] obs(input int i);
        case (i)
            0: return {8'h00, afe_operation};
            1: return {6'h00, vga_gain};
            2: return {8'h00, black_clamp_level};
            3: return {15'h0000, outputs_active};
            4: return {15'h0000, timing_core_reset};
            5: return {15'h0000, restore_enable};
            6: return {15'h0000, field_is_even};
            7: return {15'h0000, clamp_pulse_out};
            8: return {10'h000, data_out_phase};
            9: return {10'h000, init_setting_a};
            11: return {10'h000, init_setting_b};
            12: return {10'h000, afe_control};
            default: return {14'h0000, afe_operation[7:6]};
        endcase
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk(input int idx, input logic [15:0] exp);
        notes.push_back('{idx, exp});
    endtask
    initial begin
        note_type nt;
        forever begin
            @(negedge sys_clk);
            while (notes.size() != 0) begin
                nt = notes.pop_front();
                check(obs(nt.idx), nt.exp);
            end
        end
    end
    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        end_sim;
    end

    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    task automatic drive(input logic vd, input logic v);
        @(posedge sys_clk);
        if (vd) begin
            vertical_sync <= v;
        end else begin
            horizontal_sync <= v;
        end
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic pulse(input logic pol, input logic vd);
        drive(vd, ~pol);
        drive(vd, pol);
        drive(vd, ~pol);
    endtask
    task automatic sync(input logic pol, input int n);
        pulse(pol, 1);
        repeat (n) pulse(pol, 0);
        settle;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 0;
        settle;
        chk(1, 16'h0096);
        chk(2, 16'h0080);
        chk(4, 16'h0001);
        chk(5, 16'h0001);
        host_model_i.frame(8'h0F, '{6'h04});
        host_model_i.frame(8'h20, '{6'h35});
        d = rnd[5:0];
        host_model_i.frame(8'h02, '{d, 6'h05});
        settle;
        chk(1, 16'h0096);
        sync(0, 1);
        chk(9, 16'h0035);
        chk(11, 16'h0004);
        chk(1, {6'h00, 4'h5, d});
        host_model_i.frame(8'h06, '{6'h2C});
        host_model_i.frame(8'h00, '{6'h2A, 6'h03});
        settle;
        chk(0, 16'h00EA);
        chk(12, 16'h002C);
        host_model_i.frame(8'h00, '{6'h15});
        settle;
        chk(0, 16'h00EA);
        host_model_i.frame(8'h01, '{6'h01});
        settle;
        chk(10, 16'h0001);
        d = rnd[5:0];
        host_model_i.frame(8'h16, '{6'h01, 6'h00, 6'h00, 6'h01, 6'h00, d, 6'h01});
        sync(0, 1);
        chk(3, 16'h0000);
        chk(8, 16'h0000);
        host_model_i.frame(8'h19, '{6'h00});
        sync(0, 1);
        sync(0, 0);
        chk(3, 16'h0001);
        chk(8, {10'h000, d});
        chk(5, 16'h0000);
        chk(7, 16'h0001);
        chk(6, 16'h0001);
        host_model_i.frame(8'h17, '{6'h02, 6'h00});
        sync(0, 1);
        host_model_i.frame(8'h1B, '{~d});
        sync(0, 2);
        chk(8, {10'h000, d});
        pulse(0, 0);
        settle;
        chk(8, {10'h000, ~d});
        host_model_i.frame(8'h64, '{6'h00});
        host_model_i.frame(8'h1D, '{6'h01, 6'h00, 6'h01, 6'h35, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h01});
        settle;
        chk(4, 16'h0000);
        sync(1, 3);
        chk(6, 16'h0000);
        chk(7, {15'h0000, icp_prev});
        host_model_i.frame(8'h1E, '{6'h01});
        drive(1, 1);
        settle;
        chk(6, 16'h0001);
        host_model_i.frame(8'h16, '{6'h00});
        sync(1, 3);
        chk(3, 16'h0000);
        chk(7, 16'h0000);
        @(posedge sys_clk);
        preblank_pulse <= 1'b0;
        settle;
        chk(5, 16'h0001);
        settle;
        end_sim;
    end
endmodule // tb
